//--- verilog/btf_pkg.sv
// Constants, encodings and state types of the bias trim and filter command handler
// Contract
// - Filter codes 0..4 select 16..262Hz only
// - Filter reply: name, status, active code, checksum
// - Status is always the second reply field
// - New values act at once, volatile
// - Offset query: gyro XYZ, five decimals first
// - Then accelerometer XYZ with six decimals
// - Then inclinometer XYZ, seven decimals, checksum
// - Reference query returns unsigned reference, checksum
// - Program offset: all, one cluster, one axis
// - Offset value in deg/s or g
// - Cluster letter g, a or i
// - Axis letter x, y or z
// - Adjust offsets and program reference supported
package btf_pkg;
  // ==========================================================
  // Widths and limits
  localparam int VAL_W = 40;
  localparam int NF = 11;
  localparam logic [3:0] NF_LAST = 4'ha;
  localparam logic [2:0] FRAC_MAX = 3'h7;
  localparam logic [2:0] FILT_MAX = 3'h4;
  localparam logic [2:0] FILT_RST = 3'h0;
  localparam logic [2:0] NAME_MAX = 3'h5;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [VAL_W-1:0] ST_OK = 40'h0;
  localparam logic [VAL_W-1:0] ST_ERR = 40'h1;
  // ==========================================================
  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_G = 8'h67;
  localparam logic [7:0] CH_A = 8'h61;
  localparam logic [7:0] CH_I = 8'h69;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_Y = 8'h79;
  localparam logic [7:0] CH_Z = 8'h7a;
  // ==========================================================
  // Command names, left aligned, zero padded
  localparam logic [39:0] CMD_SUF = 40'h7375660000;
  localparam logic [39:0] CMD_IBTO = 40'h6962746f00;
  localparam logic [39:0] CMD_IRF = 40'h6972660000;
  localparam logic [39:0] CMD_SBTO = 40'h7362746f00;
  localparam logic [39:0] CMD_SDBTO = 40'h736462746f;
  localparam logic [39:0] CMD_SRF = 40'h7372660000;
  // ==========================================================
  // Number formats: digit position p weighs 10^(p-7) for offsets
  localparam logic [3:0] POS_TOP = 4'hb;
  localparam logic [3:0] PT_OFS = 4'h7;
  localparam logic [3:0] LO_GYR = 4'h2;
  localparam logic [3:0] LO_ACC = 4'h1;
  localparam logic [3:0] LO_INC = 4'h0;
  localparam logic [1:0] RK_NONE = 2'h0;
  localparam logic [1:0] RK_FILT = 2'h1;
  localparam logic [1:0] RK_OFFS = 2'h2;
  localparam logic [1:0] RK_REF = 2'h3;
  // ==========================================================
  // Controller states
  typedef enum logic [5:0] {
    S_RX = 6'h01,
    S_EXEC = 6'h02,
    S_HEAD = 6'h04,
    S_NUM = 6'h08,
    S_SEP = 6'h10,
    S_CR = 6'h20
  } btf_state_e;

  // Power of ten table, positions beyond the top read as zero
  function automatic logic [VAL_W-1:0] btf_pow10(input logic [3:0] p);
    case (p)
      4'h0: btf_pow10 = 40'h1;
      4'h1: btf_pow10 = 40'ha;
      4'h2: btf_pow10 = 40'h64;
      4'h3: btf_pow10 = 40'h3e8;
      4'h4: btf_pow10 = 40'h2710;
      4'h5: btf_pow10 = 40'h186a0;
      4'h6: btf_pow10 = 40'hf4240;
      4'h7: btf_pow10 = 40'h989680;
      4'h8: btf_pow10 = 40'h5f5e100;
      4'h9: btf_pow10 = 40'h3b9aca00;
      4'ha: btf_pow10 = 40'h2540be400;
      4'hb: btf_pow10 = 40'h174876e800;
      default: btf_pow10 = 40'h0;
    endcase
  endfunction
endpackage

//--- verilog/btf_crc8.sv
// Byte-wide CRC-8 step, MSB first
`timescale 1ns/1ns
`default_nettype none
module btf_crc8 #(
  parameter logic [7:0] POLY = 8'h07
) (
  // Running value and new byte
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  // Updated value
  output logic [7:0] crc_out
);
  // ==========================================================
  // One shift stage per bit
  logic [7:0] c [0:8];
  assign c[0] = crc_in ^ data;
  genvar i;
  for (i = 0; i < 8; i++) begin : g_bit
    assign c[i+1] = c[i][7] ? ({c[i][6:0], 1'b0} ^ POLY) : {c[i][6:0], 1'b0};
  end
  assign crc_out = c[8];
endmodule
`default_nettype wire

//--- verilog/btf_cmd_handler.sv
// ASCII command handler for auxiliary filter and bias trim offsets
`timescale 1ns/1ns
`default_nettype none
module btf_cmd_handler
  import btf_pkg::*;
#(
  parameter int REF_W = 32
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Received command bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Response bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Active parameters
  output logic [2:0] aux_lp_code,
  output logic [8:0][VAL_W-1:0] trim_offset,
  output logic [REF_W-1:0] trim_ref
);
  btf_state_e state_ff, nxt_state;
  logic signed [VAL_W-1:0] fval_ff [0:NF-1], nxt_fval [0:NF-1];
  logic [2:0] ffrac_ff [0:NF-1], nxt_ffrac [0:NF-1];
  logic [7:0] fchr_ff [0:NF-1], nxt_fchr [0:NF-1];
  logic [NF-1:0] fpt_ff, nxt_fpt, fnum_ff, nxt_fnum;
  logic [VAL_W-1:0] mag_ff, nxt_mag, rem_ff, nxt_rem;
  logic [39:0] name_ff, nxt_name;
  logic [3:0] fld_ff, nxt_fld, j_ff, nxt_j, pos_ff, nxt_pos, dig_ff, nxt_dig, ci_ff, nxt_ci;
  logic [2:0] frac_ff, nxt_frac, nlen_ff, nxt_nlen, filt_ff, nxt_filt;
  logic [7:0] chr_ff, nxt_chr, crc_ff, nxt_crc, crc_chk_ff, nxt_crc_chk, tx_data_ff, nxt_tx_data;
  logic neg_ff, nxt_neg, pnt_ff, nxt_pnt, alpha_ff, nxt_alpha, dg_ff, nxt_dg;
  logic act_ff, nxt_act, bad_ff, nxt_bad, err_ff, nxt_err, tx_valid_ff, nxt_tx_valid;
  logic tx_cnt_ff, nxt_tx_cnt, rx_ready_ff, nxt_rx_ready;
  logic sg_ff, nxt_sg, ppt_ff, nxt_ppt, started_ff, nxt_started, oneg_ff, nxt_oneg;
  logic [1:0] rk_ff, nxt_rk, cl, ax;
  logic [VAL_W-1:0] trim_ff [0:8], nxt_trim [0:8];
  logic [REF_W-1:0] ref_ff, nxt_ref;
  logic signed [VAL_W-1:0] scl [0:NF-1];
  logic signed [VAL_W-1:0] v;
  logic [3:0] pc, cnt, lo, pt;
  logic [7:0] ec, crc_base, crc_dat, crc_nx;
  logic em, slot, take, is_close, crc_ok, ok, adj_ok;
  logic is_suf, is_ibto, is_irf, is_sbto, is_sdbto, is_srf;

  // ==========================================================
  // Checksum: fed by received bytes while listening, sent bytes otherwise
  assign crc_dat = (state_ff == S_RX) ? rx_data : tx_data_ff;
  assign crc_base = (state_ff == S_RX && rx_data == CH_DOLLAR) ? CRC_INIT : crc_ff;
  btf_crc8 #(.POLY(CRC_POLY)) u_crc (.crc_in(crc_base), .data(crc_dat), .crc_out(crc_nx));

  // ==========================================================
  // Command decode and validation
  always_comb begin
    pc = fld_ff - 4'h1;
    for (int k = 0; k < NF; k++) begin
      scl[k] = VAL_W'(fval_ff[k] * $signed(btf_pow10({1'b0, FRAC_MAX - ffrac_ff[k]})));
    end
    crc_ok = fld_ff != 4'h0 && !bad_ff && fnum_ff[fld_ff] && !fpt_ff[fld_ff]
      && fval_ff[fld_ff] == $signed({32'h0, crc_chk_ff});
    is_suf = name_ff == CMD_SUF;
    is_ibto = name_ff == CMD_IBTO;
    is_irf = name_ff == CMD_IRF;
    is_sbto = name_ff == CMD_SBTO;
    is_sdbto = name_ff == CMD_SDBTO;
    is_srf = name_ff == CMD_SRF;
    // Cluster and axis letters, 3 marks an invalid letter
    cl = (fchr_ff[2] == CH_G) ? 2'h0 : (fchr_ff[2] == CH_A) ? 2'h1 :
         (fchr_ff[2] == CH_I) ? 2'h2 : 2'h3;
    ax = (fchr_ff[3] == CH_X) ? 2'h0 : (fchr_ff[3] == CH_Y) ? 2'h1 :
         (fchr_ff[3] == CH_Z) ? 2'h2 : 2'h3;
    adj_ok = pc == 4'h9 && (&fnum_ff[9:1]);
    ok = crc_ok && (
      (is_suf && pc == 4'h1 && fnum_ff[1] && !fpt_ff[1] && fval_ff[1] >= 0
        && fval_ff[1] <= $signed({37'h0, FILT_MAX})) ||
      ((is_ibto || is_irf) && pc == 4'h0) ||
      (is_sbto && fnum_ff[1] && (pc == 4'h1 || (pc == 4'h2 && cl != 2'h3)
        || (pc == 4'h3 && cl != 2'h3 && ax != 2'h3))) ||
      (is_sdbto && adj_ok) ||
      (is_srf && pc == 4'h1 && fnum_ff[1] && !fpt_ff[1] && fval_ff[1] >= 0));
    // Reply shape: count of numbers after the name, checksum excluded
    cnt = (rk_ff == RK_OFFS) ? 4'ha : (rk_ff == RK_NONE) ? 4'h1 : 4'h2;
    pt = (rk_ff == RK_OFFS && j_ff != 4'h0 && j_ff != cnt) ? PT_OFS : 4'h0;
    lo = (pt == 4'h0) ? 4'h0 : (j_ff <= 4'h3) ? LO_GYR :
         (j_ff <= 4'h6) ? LO_ACC : LO_INC;
    if (j_ff == cnt) v = $signed({32'h0, crc_ff});
    else if (j_ff == 4'h0) v = err_ff ? ST_ERR : ST_OK;
    else if (rk_ff == RK_FILT) v = $signed({37'h0, filt_ff});
    else if (rk_ff == RK_REF) v = $signed(VAL_W'(ref_ff));
    else v = trim_ff[j_ff - 4'h1];
  end

  // ==========================================================
  // Main sequencer: parse, execute, reply
  always_comb begin
    nxt_state = state_ff; nxt_fval = fval_ff; nxt_ffrac = ffrac_ff; nxt_fchr = fchr_ff;
    nxt_fpt = fpt_ff; nxt_fnum = fnum_ff; nxt_mag = mag_ff; nxt_rem = rem_ff;
    nxt_name = name_ff; nxt_fld = fld_ff; nxt_j = j_ff; nxt_pos = pos_ff;
    nxt_dig = dig_ff; nxt_ci = ci_ff; nxt_frac = frac_ff; nxt_nlen = nlen_ff;
    nxt_filt = filt_ff; nxt_chr = chr_ff; nxt_crc = crc_ff; nxt_crc_chk = crc_chk_ff;
    nxt_neg = neg_ff; nxt_pnt = pnt_ff; nxt_alpha = alpha_ff; nxt_dg = dg_ff;
    nxt_act = act_ff; nxt_bad = bad_ff; nxt_err = err_ff; nxt_sg = sg_ff;
    nxt_ppt = ppt_ff; nxt_started = started_ff; nxt_oneg = oneg_ff; nxt_rk = rk_ff;
    nxt_trim = trim_ff; nxt_ref = ref_ff; nxt_tx_cnt = tx_cnt_ff;
    em = 1'b0; ec = 8'h00; is_close = 1'b0;
    slot = !tx_valid_ff || tx_ready;
    take = rx_valid && rx_ready_ff && state_ff == S_RX;
    // Sent bytes up to the last comma enter the reply checksum
    if (state_ff != S_RX && tx_valid_ff && tx_ready && tx_cnt_ff) nxt_crc = crc_nx;
    case (state_ff)
      S_RX: begin
        if (take && rx_data == CH_DOLLAR) begin
          nxt_act = 1'b1; nxt_crc = crc_nx; nxt_fld = 4'h0; nxt_nlen = 3'h0;
          nxt_name = 40'h0; nxt_bad = 1'b0; is_close = 1'b1;
        end else if (take && act_ff && rx_data == CH_CR) begin
          is_close = 1'b1; nxt_act = 1'b0; nxt_state = S_EXEC;
        end else if (take && act_ff) begin
          nxt_crc = crc_nx;
          if (rx_data == CH_COMMA) begin
            nxt_crc_chk = crc_nx; is_close = 1'b1;
            if (fld_ff == NF_LAST) nxt_bad = 1'b1;
            else nxt_fld = fld_ff + 4'h1;
          end else if (fld_ff == 4'h0) begin
            if (nlen_ff == NAME_MAX) nxt_bad = 1'b1;
            else begin
              nxt_name[39 - 8 * nlen_ff -: 8] = rx_data; nxt_nlen = nlen_ff + 3'h1;
            end
          end else if (rx_data >= CH_0 && rx_data <= CH_9) begin
            nxt_dg = 1'b1;
            // Digits past the seventh decimal or past the range are dropped
            if (!(pnt_ff && frac_ff == FRAC_MAX) && mag_ff < btf_pow10(4'ha)) begin
              nxt_mag = VAL_W'(mag_ff * 40'ha) + VAL_W'(rx_data[3:0]);
              if (pnt_ff) nxt_frac = frac_ff + 3'h1;
            end
          end else if (rx_data == CH_DOT) begin
            if (pnt_ff) nxt_bad = 1'b1;
            nxt_pnt = 1'b1;
          end else if (rx_data == CH_MINUS) begin
            if (dg_ff || neg_ff) nxt_bad = 1'b1;
            nxt_neg = 1'b1;
          end else begin
            nxt_chr = rx_data; nxt_alpha = 1'b1;
          end
        end
      end
      S_EXEC: begin
        nxt_err = !ok; nxt_state = S_HEAD; nxt_ci = 4'h0; nxt_crc = CRC_INIT;
        nxt_rk = is_suf ? RK_FILT : (is_irf || is_srf) ? RK_REF :
                 (is_ibto || is_sbto || is_sdbto) ? RK_OFFS : RK_NONE;
        // Volatile update, effective from the next cycle
        if (ok && is_suf) nxt_filt = fval_ff[1][2:0];
        if (ok && is_srf) nxt_ref = REF_W'(fval_ff[1]);
        for (int k = 0; k < 9; k++) begin
          if (ok && is_sdbto) nxt_trim[k] = VAL_W'(trim_ff[k] + scl[k+1]);
          if (ok && is_sbto && (pc == 4'h1 || (cl == 2'(k / 3)
              && (pc == 4'h2 || ax == 2'(k % 3))))) nxt_trim[k] = scl[1];
        end
      end
      S_HEAD: if (slot) begin
        em = 1'b1;
        if (ci_ff == 4'h0) ec = CH_HASH;
        else if (ci_ff <= {1'b0, nlen_ff}) ec = name_ff[47 - 8 * ci_ff -: 8];
        else begin
          ec = CH_COMMA; nxt_state = S_NUM; nxt_j = 4'h0; nxt_sg = 1'b0;
        end
        nxt_ci = ci_ff + 4'h1;
      end
      S_NUM: if (slot && (j_ff != cnt || !tx_valid_ff)) begin
        if (!sg_ff) begin
          // Checksum value is only final once the last comma has left
          nxt_sg = 1'b1; nxt_oneg = v < 0; nxt_rem = (v < 0) ? VAL_W'(-v) : v;
          nxt_pos = POS_TOP; nxt_dig = 4'h0; nxt_started = 1'b0; nxt_ppt = 1'b0;
          em = v < 0; ec = CH_MINUS;
        end else if (ppt_ff) begin
          em = 1'b1; ec = CH_DOT; nxt_ppt = 1'b0;
        end else if (rem_ff >= btf_pow10(pos_ff)) begin
          nxt_rem = rem_ff - btf_pow10(pos_ff); nxt_dig = dig_ff + 4'h1;
        end else begin
          if (started_ff || dig_ff != 4'h0 || pos_ff <= pt) begin
            em = 1'b1; ec = CH_0 + {4'h0, dig_ff}; nxt_started = 1'b1;
          end
          if (pos_ff == lo) nxt_state = (j_ff == cnt) ? S_CR : S_SEP;
          else begin
            nxt_pos = pos_ff - 4'h1; nxt_dig = 4'h0;
            nxt_ppt = pos_ff == pt;
          end
        end
      end
      S_SEP: if (slot) begin
        em = 1'b1; ec = CH_COMMA; nxt_j = j_ff + 4'h1; nxt_sg = 1'b0; nxt_state = S_NUM;
      end
      S_CR: if (slot) begin
        em = 1'b1; ec = CH_CR; nxt_state = S_RX;
      end
      default: nxt_state = S_RX;
    endcase
    // Store the finished field and clear the accumulators
    if (is_close) begin
      if (state_ff == S_RX && rx_data != CH_DOLLAR && fld_ff != 4'h0) begin
        nxt_fval[fld_ff] = neg_ff ? -$signed(mag_ff) : $signed(mag_ff);
        nxt_ffrac[fld_ff] = frac_ff; nxt_fpt[fld_ff] = pnt_ff;
        nxt_fchr[fld_ff] = alpha_ff ? chr_ff : 8'h00; nxt_fnum[fld_ff] = dg_ff && !alpha_ff;
      end
      nxt_mag = '0; nxt_frac = 3'h0; nxt_neg = 1'b0; nxt_pnt = 1'b0;
      nxt_alpha = 1'b0; nxt_dg = 1'b0; nxt_chr = 8'h00;
    end
    if (em) nxt_tx_cnt = !(state_ff == S_NUM && j_ff == cnt) && state_ff != S_CR;
    nxt_tx_valid = em || (tx_valid_ff && !tx_ready);
    nxt_tx_data = em ? ec : tx_data_ff;
    nxt_rx_ready = nxt_state == S_RX;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_RX; fval_ff <= '{default: '0}; ffrac_ff <= '{default: '0};
      fchr_ff <= '{default: '0}; fpt_ff <= '0; fnum_ff <= '0; mag_ff <= '0; rem_ff <= '0;
      name_ff <= '0; fld_ff <= '0; j_ff <= '0; pos_ff <= '0; dig_ff <= '0; ci_ff <= '0;
      frac_ff <= '0; nlen_ff <= '0; filt_ff <= FILT_RST; chr_ff <= '0; crc_ff <= CRC_INIT;
      crc_chk_ff <= '0; neg_ff <= 1'b0; pnt_ff <= 1'b0; alpha_ff <= 1'b0; dg_ff <= 1'b0;
      act_ff <= 1'b0; bad_ff <= 1'b0; err_ff <= 1'b0; sg_ff <= 1'b0; ppt_ff <= 1'b0;
      started_ff <= 1'b0; oneg_ff <= 1'b0; rk_ff <= RK_NONE; trim_ff <= '{default: '0};
      ref_ff <= '0; tx_cnt_ff <= 1'b0; tx_valid_ff <= 1'b0; tx_data_ff <= 8'h00;
      rx_ready_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state; fval_ff <= nxt_fval; ffrac_ff <= nxt_ffrac;
      fchr_ff <= nxt_fchr; fpt_ff <= nxt_fpt; fnum_ff <= nxt_fnum; mag_ff <= nxt_mag;
      rem_ff <= nxt_rem; name_ff <= nxt_name; fld_ff <= nxt_fld; j_ff <= nxt_j;
      pos_ff <= nxt_pos; dig_ff <= nxt_dig; ci_ff <= nxt_ci; frac_ff <= nxt_frac;
      nlen_ff <= nxt_nlen; filt_ff <= nxt_filt; chr_ff <= nxt_chr; crc_ff <= nxt_crc;
      crc_chk_ff <= nxt_crc_chk; neg_ff <= nxt_neg; pnt_ff <= nxt_pnt; alpha_ff <= nxt_alpha;
      dg_ff <= nxt_dg; act_ff <= nxt_act; bad_ff <= nxt_bad; err_ff <= nxt_err;
      sg_ff <= nxt_sg; ppt_ff <= nxt_ppt; started_ff <= nxt_started; oneg_ff <= nxt_oneg;
      rk_ff <= nxt_rk; trim_ff <= nxt_trim; ref_ff <= nxt_ref; tx_cnt_ff <= nxt_tx_cnt;
      tx_valid_ff <= nxt_tx_valid; tx_data_ff <= nxt_tx_data; rx_ready_ff <= nxt_rx_ready;
    end
  end

  // Outputs straight from registers
  assign rx_ready = rx_ready_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign aux_lp_code = filt_ff;
  assign trim_ref = ref_ff;
  for (genvar g = 0; g < 9; g++) begin : g_trim
    assign trim_offset[g] = trim_ff[g];
  end

  // ==========================================================
  // Checks, suspended while the enable is low
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  a_filt_range: assert property (filt_ff <= FILT_MAX)
    else $error("filter code out of range");
  a_filt_apply: assert property ((state_ff == S_EXEC && ok && is_suf)
    |=> filt_ff == $past(fval_ff[1][2:0])) else $error("filter code not applied");
  a_bad_hold: assert property ((state_ff == S_EXEC && !ok)
    |=> $stable(filt_ff) && $stable(ref_ff) && $stable(trim_ff[0]) && err_ff)
    else $error("failed command changed parameters");
  a_reply_start: assert property ((state_ff == S_EXEC && !tx_valid_ff)
    |=> ##1 tx_valid_ff && tx_data_ff == CH_HASH) else $error("reply did not start");
  a_status_digit: assert property ((state_ff == S_NUM && j_ff == 4'h0 && em
    && ec != CH_MINUS) |-> ec == CH_0 + {7'h0, err_ff}) else $error("status field wrong");
  a_gyro_format: assert property ((state_ff == S_NUM && rk_ff == RK_OFFS
    && j_ff >= 4'h1 && j_ff <= 4'h3) |-> lo == LO_GYR && pt == PT_OFS)
    else $error("gyro offset format wrong");
  a_acc_format: assert property ((state_ff == S_NUM && rk_ff == RK_OFFS
    && j_ff >= 4'h4 && j_ff <= 4'h6) |-> lo == LO_ACC) else $error("accel format wrong");
  a_inc_format: assert property ((state_ff == S_NUM && rk_ff == RK_OFFS
    && j_ff >= 4'h7 && j_ff <= 4'h9) |-> lo == LO_INC && cnt == 4'ha)
    else $error("incl format wrong");
  a_ref_apply: assert property ((state_ff == S_EXEC && ok && is_srf)
    |=> ref_ff == REF_W'($past(fval_ff[1]))) else $error("reference not stored");
  a_adjust_add: assert property ((state_ff == S_EXEC && ok && is_sdbto)
    |=> trim_ff[0] == VAL_W'($past(trim_ff[0]) + $past(scl[1]))) else $error("adjust wrong");
  a_cluster_keep: assert property ((state_ff == S_EXEC && ok && is_sbto
    && pc == 4'h2 && cl != 2'h0) |=> $stable(trim_ff[0])) else $error("wrong cluster hit");
  c_filt_ok: cover property (state_ff == S_EXEC && ok && is_suf);
  c_axis_ok: cover property (state_ff == S_EXEC && ok && is_sbto && pc == 4'h3);
  c_crc_bad: cover property (state_ff == S_EXEC && !crc_ok);
endmodule
`default_nettype wire

//--- dv/btf_host_model.sv
// Host controller model: sends command bytes and collects the response
`timescale 1ns/1ns
`default_nettype none
module btf_host_model (
  // Clock
  input wire logic clk,
  // Command byte stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Response byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  string resp;
  logic resp_done;
  logic hit;
  logic slow;
  // ==========================================================
  // Idle state at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    resp = "";
    resp_done = 1'b0;
    hit = 1'b0;
    slow = 1'b0;
  end
  // Byte taken flag, read back at the next falling edge to avoid races
  always @(posedge clk) hit <= rx_valid & rx_ready;
  // Slow sink stalls every other cycle, so the handler must hold its byte
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  // Collect response bytes until the carriage return
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      resp = {resp, string'(tx_data)};
      if (tx_data == 8'h0d) begin
        resp_done = 1'b1;
      end
    end
  end
  // Offer each byte until taken; a released data line shows the inverse
  task automatic send(input string s);
    resp = "";
    resp_done = 1'b0;
    @(negedge clk);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid = 1'b1;
      rx_data = s[i];
      do @(negedge clk); while (!hit);
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking testbench of the bias trim and filter command handler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import btf_pkg::*;
  logic clk, rst_n, ce, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [2:0] aux_lp_code;
  logic [8:0][VAL_W-1:0] trim_offset;
  logic [31:0] trim_ref;
  int mismatches = 0;
  int n_compared = 0;
  // ==========================================================
  // Design and host model
  btf_cmd_handler #(.REF_W(32)) u_btf_cmd_handler (.clk(clk), .rst_n(rst_n), .ce(ce),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .aux_lp_code(aux_lp_code),
    .trim_offset(trim_offset), .trim_ref(trim_ref));
  btf_host_model u_btf_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // ==========================================================
  // Shared helpers
  task automatic check(input string name, input logic [VAL_W-1:0] seen,
                       input logic [VAL_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Own checksum model, kept apart from the design's step logic
  function automatic logic [7:0] crc8(input string s);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < s.len(); i++) begin
      c = c ^ s[i];
      repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // One command; adj spoils the checksum on purpose when nonzero
  task automatic xact(input string body, input int adj);
    int n;
    n = 0;
    u_btf_host_model.send({"$", body, $sformatf("%0d", crc8({"$", body}) + adj), "\r"});
    while (u_btf_host_model.resp_done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check("response done", u_btf_host_model.resp_done, 1'b1);
    check("ready after reply", rx_ready, 1'b1);
  endtask
  task automatic cmp_resp(input string exp);
    string e;
    e = {"#", exp, $sformatf("%0d", crc8({"#", exp})), "\r"};
    check("response length", u_btf_host_model.resp.len(), e.len());
    for (int i = 0; i < e.len(); i++) begin
      check("response char", u_btf_host_model.resp[i], e[i]);
    end
  endtask
  task automatic t_filter;
    for (int c = 0; c < 5; c++) begin
      u_btf_host_model.slow = c[0];
      xact($sformatf("suf,%0d,", c), 0);
      cmp_resp($sformatf("suf,0,%0d,", c));
      check("filter code", aux_lp_code, c);
    end
    xact("suf,5,", 0);
    cmp_resp("suf,1,4,");
    xact("suf,1,", 1);
    cmp_resp("suf,1,4,");
    check("filter kept", aux_lp_code, 3'h4);
  endtask
  task automatic t_offsets;
    string ax = "xyz";
    string gv[3] = '{"0.01388", "-0.02425", "0.01724"};
    int gx[3] = '{138800, -242500, 172400};
    xact("sbto,0,", 0);
    check("sbto status", u_btf_host_model.resp.substr(0, 7) == "#sbto,0,", 1'b1);
    for (int i = 0; i < 3; i++) begin
      xact({"sbto,", gv[i], ",g,", string'(ax[i]), ","}, 0);
      check("gyro offset", trim_offset[i], VAL_W'(gx[i]));
    end
    xact("sbto,-0.036230,a,", 0);
    for (int i = 3; i < 6; i++) check("acc offset", trim_offset[i], VAL_W'(-362300));
    xact("sbto,0.0083054,i,z,", 0);
    check("inc z offset", trim_offset[8], VAL_W'(83054));
    check("inc x offset", trim_offset[6], VAL_W'(0));
    xact("ibto,", 0);
    cmp_resp({"ibto,0,0.01388,-0.02425,0.01724,-0.036230,-0.036230,-0.036230,",
              "0.0000000,0.0000000,0.0083054,"});
  endtask
  task automatic t_ref;
    xact("srf,43638,", 0);
    cmp_resp("srf,0,43638,");
    check("reference", trim_ref, 32'haa76);
    xact("irf,", 0);
    cmp_resp("irf,0,43638,");
    xact("sdbto,0.00001,0,0,0,0,0,0,0,-0.0000001,", 0);
    check("adjusted gyro x", trim_offset[0], VAL_W'(138900));
    check("adjusted inc z", trim_offset[8], VAL_W'(83053));
  endtask
  // Values last only until reset; the host never issues a save command
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    ce = 1'b0;
    repeat (2) @(negedge clk);
    check("ready in reset", rx_ready, 1'b0);
    rst_n = 1'b1;
    check("filter after reset", aux_lp_code, 3'h0);
    check("offset after reset", trim_offset[0], VAL_W'(0));
    check("reference after reset", trim_ref, 32'h0);
    // Enable low freezes all state, so the handler must not start listening
    repeat (3) @(negedge clk);
    check("ready frozen", rx_ready, 1'b0);
    ce = 1'b1;
    @(negedge clk);
    check("ready after enable", rx_ready, 1'b1);
    xact("suf,3,", 0);
    cmp_resp("suf,0,3,");
    check("filter after restart", aux_lp_code, 3'h3);
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check("filter at reset", aux_lp_code, 3'h0);
    t_filter();
    t_offsets();
    t_ref();
    t_reset();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of some 3000 cycles
  initial begin
    #600000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
